// *** src/shutter_pkg.sv ***
package shutter_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 24;
    localparam int CNT_W = 12;
    localparam int RDN_W = 3;

    localparam logic [ADDR_W-1:0] OFS_EXPOSURE_FIELD_COUNT = 8'h63;
    localparam logic [ADDR_W-1:0] OFS_PULSES_PER_FIELD = 8'h64;
    localparam logic [ADDR_W-1:0] OFS_EXTRA_MASK_MODE = 8'h65;
    localparam logic [ADDR_W-1:0] OFS_OPERATION_TRIGGER = 8'h66;
    localparam logic [ADDR_W-1:0] OFS_READOUT_FIELD_COUNT = 8'h67;
    localparam logic [ADDR_W-1:0] OFS_SYNC_OFF = 8'h68;
    localparam logic [ADDR_W-1:0] OFS_PULSE_START_POLARITY = 8'h69;
    localparam logic [ADDR_W-1:0] OFS_FIRST_PULSE_TOGGLES = 8'h6A;
    localparam logic [ADDR_W-1:0] OFS_SECOND_PULSE_TOGGLES = 8'h6B;
    localparam logic [ADDR_W-1:0] OFS_POST_GATE_SUPPRESS = 8'h6C;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h6D;

    localparam logic [CNT_W-1:0] RST_PULSES_PER_FIELD = 12'h001;
    localparam logic [2*CNT_W-1:0] RST_SECOND_TOGGLES = 24'hFFFFFF;
    localparam logic [2*CNT_W-1:0] SECOND_PULSE_OFF = 24'hFFFFFF;

    localparam int TRIG_SHUT_LO = 0;
    localparam int TRIG_BIAS_HI = 5;
    localparam int TRIG_EXPOSURE = 6;
    localparam int TRIG_READOUT = 7;

    localparam logic [1:0] MASK_NONE = 2'h0;
    localparam logic [1:0] MASK_FROM_FIELD = 2'h1;
    localparam logic [1:0] MASK_SHUTTER3 = 2'h2;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_EXPOSE, SEQ_READOUT} seq_e;

    typedef struct packed {
        logic line_start;
        logic field_start;
        logic gate_line;
    } timing_s;

    typedef struct packed {
        logic polarity;
        logic [CNT_W-1:0] tog1_a;
        logic [CNT_W-1:0] tog1_b;
        logic [CNT_W-1:0] tog2_a;
        logic [CNT_W-1:0] tog2_b;
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] suppress;
        logic [1:0] mask;
    } pulse_cfg_s;

endpackage

// *** src/substrate_shutter_sequencer.sv ***
// What this block does
// RL1 - One substrate pulse per line, count programmable
// RL2 - Start polarity and two toggle positions per line
// RL3 - Pulses start on line after gate line
// RL4 - Pulse settings load on line after gate
// RL5 - High precision adds second pulse on last line
// RL6 - Second toggles at maximum disable extra pulse
// RL7 - Long exposure suppresses substrate and gate fields
// RL8 - Sync-off bit stops syncs during exposure
// RL9 - Exposure trigger bit starts at next field
// RL10 - Zero exposure count behaves like normal operation
// RL11 - Suppress programmable pulses after gate line
// RL12 - Untriggered, gate and substrate pulse every field
// RL13 - Readout suppresses substrate for programmed fields
// RL14 - Software programs readout count once at startup
// RL15 - Readout starts only from trigger bit seven
// RL16 - Joint trigger runs readout after exposure ends
// RL17 - Readout-only trigger starts at next field
// RL18 - Extra mask: none, from field, shutter three
// RL19 - Trigger register holds eight one-shot requests
// RL20 - Manual mode needs per-field rewrites by software
// RL21 - Count one less for pulses in last field
// RL22 - Fields counted per edge, triggers consumed once
`timescale 1ns/10ps
`default_nettype none

module substrate_shutter_sequencer
    import shutter_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic REG_WE,
    input wire logic REG_RE,
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic [DATA_W-1:0] REG_WDATA,
    output logic [DATA_W-1:0] REG_RDATA,
    input wire timing_s TIMING,
    input wire logic SHUTTER_SIGNAL_THREE,
    output logic SUBSTRATE_PULSE,
    output logic SENSOR_GATE_ENABLE,
    output logic SYNC_ENABLE,
    output logic [TRIG_BIAS_HI:0] SHUTTER_TRIGGER,
    output logic EXPOSING,
    output logic READING
);

    // Elaboration checks: the register map and field positions assume
    // these widths, so other address, count and readout widths or a narrower data bus are refused
    if (ADDR_W != 8) begin : g_bad_addr
        $error("Register address must be 8 bits wide");
    end
    if (DATA_W < 2 * CNT_W) begin : g_bad_data
        $error("Register data too narrow for a toggle pair");
    end
    if (CNT_W != 12) begin : g_bad_count
        $error("Pulse and field counters must be 12 bits wide");
    end
    if (RDN_W != 3 || RDN_W > CNT_W) begin : g_bad_readout
        $error("Readout field count must be 3 bits wide");
    end
    if (TRIG_EXPOSURE != 6 || TRIG_READOUT != 7) begin : g_bad_trig
        $error("Exposure and readout requests must sit in bits 6 and 7");
    end
    if (TRIG_SHUT_LO != 0 || TRIG_BIAS_HI != 5) begin : g_bad_shut
        $error("Shutter and bias requests must fill bits 0 to 5");
    end

    // Software-side copies; the pulse logic only sees the shadow set
    logic [CNT_W-1:0] exposure_field_count;
    logic [RDN_W-1:0] readout_field_count;
    logic sync_off_during_exposure;
    pulse_cfg_s cfg;
    pulse_cfg_s active;
    logic [7:0] operation_trigger;
    logic [7:0] consume;

    logic [CNT_W-1:0] pixel;
    logic [CNT_W-1:0] line_idx;
    logic gate_seen;
    logic lines_valid;
    logic field_mask;
    logic sub_level;

    // fields_left serves the exposure countdown first, then the readout
    // one; a single counter is enough since the two never overlap
    seq_e state;
    logic [CNT_W-1:0] fields_left;
    logic joint_readout;
    logic exp_suppress;
    logic rd_suppress;

    function automatic logic hit(input logic [CNT_W-1:0] pos, input logic [CNT_W-1:0] a,
                                 input logic [CNT_W-1:0] b);
        hit = (pos == a) ^ (pos == b);
    endfunction

    // A readout count of zero means no readout suppression at all
    function automatic logic readout_wanted(input logic [RDN_W-1:0] n);
        readout_wanted = n != '0;
    endfunction

    // Trigger writes set pending requests instead of overwriting them
    logic wr_hit_trigger;
    assign wr_hit_trigger = REG_WE && REG_ADDR == OFS_OPERATION_TRIGGER;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            exposure_field_count <= '0;
            readout_field_count <= '0;
            sync_off_during_exposure <= 1'b0;
            cfg <= '0;
            cfg.count <= RST_PULSES_PER_FIELD;
            {cfg.tog2_a, cfg.tog2_b} <= RST_SECOND_TOGGLES;
        end else if (REG_WE) begin
            // Unmapped and status writes fall through and are dropped
            case (REG_ADDR)
                OFS_EXPOSURE_FIELD_COUNT: exposure_field_count <= REG_WDATA[CNT_W-1:0];
                OFS_PULSES_PER_FIELD: cfg.count <= REG_WDATA[CNT_W-1:0];
                OFS_EXTRA_MASK_MODE: cfg.mask <= REG_WDATA[1:0];
                OFS_READOUT_FIELD_COUNT: readout_field_count <= REG_WDATA[RDN_W-1:0];
                OFS_SYNC_OFF: sync_off_during_exposure <= REG_WDATA[0];
                OFS_PULSE_START_POLARITY: cfg.polarity <= REG_WDATA[0];
                OFS_FIRST_PULSE_TOGGLES: {cfg.tog1_b, cfg.tog1_a} <= REG_WDATA[2*CNT_W-1:0];
                OFS_SECOND_PULSE_TOGGLES: {cfg.tog2_b, cfg.tog2_a} <= REG_WDATA[2*CNT_W-1:0];
                OFS_POST_GATE_SUPPRESS: cfg.suppress <= REG_WDATA[CNT_W-1:0];
                default: ;
            endcase
        end
    end

    // Requests stay pending until a field edge accepts them; a write wins
    // over a consume in the same cycle so no request is lost
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            operation_trigger <= '0;
        end else begin
            operation_trigger <= (operation_trigger & ~consume)
                | (wr_hit_trigger ? REG_WDATA[7:0] : 8'h00); // [RL19] [RL22]
        end
    end

    // Read data is registered and holds until the next read strobe
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            REG_RDATA <= '0;
        end else if (REG_RE) begin
            case (REG_ADDR)
                OFS_EXPOSURE_FIELD_COUNT: REG_RDATA <= DATA_W'(exposure_field_count);
                OFS_PULSES_PER_FIELD: REG_RDATA <= DATA_W'(cfg.count);
                OFS_EXTRA_MASK_MODE: REG_RDATA <= DATA_W'(cfg.mask);
                OFS_OPERATION_TRIGGER: REG_RDATA <= DATA_W'(operation_trigger);
                OFS_READOUT_FIELD_COUNT: REG_RDATA <= DATA_W'(readout_field_count);
                OFS_SYNC_OFF: REG_RDATA <= DATA_W'(sync_off_during_exposure);
                OFS_PULSE_START_POLARITY: REG_RDATA <= DATA_W'(cfg.polarity);
                OFS_FIRST_PULSE_TOGGLES: REG_RDATA <= DATA_W'({cfg.tog1_b, cfg.tog1_a});
                OFS_SECOND_PULSE_TOGGLES: REG_RDATA <= DATA_W'({cfg.tog2_b, cfg.tog2_a});
                OFS_POST_GATE_SUPPRESS: REG_RDATA <= DATA_W'(cfg.suppress);
                // Status: remaining fields above the two state bits
                OFS_STATUS: REG_RDATA <= DATA_W'({fields_left, 2'b00, READING, EXPOSING});
                default: REG_RDATA <= '0;
            endcase
        end
    end

    // Pixel counter saturates, so a missing line start cannot wrap it
    // round into a second set of toggles
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pixel <= '0;
        end else if (TIMING.line_start) begin
            pixel <= '0;
        end else if (pixel != '1) begin
            pixel <= pixel + 1'b1;
        end
    end

    // Shadow load and line numbering restart on the line after the gate line
    // A gate line that is still high at that start arms the next reload
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            gate_seen <= 1'b0;
            active <= '0;
            active.count <= RST_PULSES_PER_FIELD;
            {active.tog2_a, active.tog2_b} <= RST_SECOND_TOGGLES;
            line_idx <= '0;
            lines_valid <= 1'b0;
        end else if (TIMING.line_start && gate_seen) begin
            gate_seen <= TIMING.gate_line;
            active <= cfg; // [RL4]
            line_idx <= '0; // [RL3]
            lines_valid <= 1'b1;
        end else begin
            if (TIMING.gate_line) begin
                gate_seen <= 1'b1;
            end
            if (TIMING.line_start && line_idx != '1) begin
                line_idx <= line_idx + 1'b1;
            end
        end
    end

    // Mode 1 masks from the field edge until the next gate line reload
    // A field edge in the reload cycle keeps the mask set
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            field_mask <= 1'b0;
        end else if (TIMING.field_start) begin
            field_mask <= 1'b1;
        end else if (TIMING.line_start && gate_seen) begin
            field_mask <= 1'b0;
        end
    end

    // Line window arithmetic is one bit wider so suppress plus count
    // cannot wrap back below the line index
    logic [CNT_W:0] first_line;
    logic [CNT_W:0] end_line;
    logic pulse_line;
    logic last_line;
    logic extra_on;
    logic masked;
    logic blocked;
    logic first_hit;
    logic second_hit;

    // Pulse lines run from the suppress count for count lines; the last
    // of them may carry the extra high-precision pulse
    always_comb begin
        first_line = {1'b0, active.suppress}; // [RL11]
        end_line = first_line + {1'b0, active.count};
        pulse_line = lines_valid && {1'b0, line_idx} >= first_line
            && {1'b0, line_idx} < end_line; // [RL1]
        last_line = pulse_line && ({1'b0, line_idx} + 1'b1) == end_line;
        extra_on = {active.tog2_a, active.tog2_b} != SECOND_PULSE_OFF; // [RL6]
        first_hit = hit(pixel, active.tog1_a, active.tog1_b); // [RL2]
        second_hit = last_line && extra_on && hit(pixel, active.tog2_a, active.tog2_b); // [RL5]
        case (active.mask)
            MASK_FROM_FIELD: masked = field_mask; // [RL18]
            MASK_SHUTTER3: masked = SHUTTER_SIGNAL_THREE; // [RL18]
            // Mode 3 is reserved and behaves as no mask
            default: masked = 1'b0;
        endcase
        blocked = masked || exp_suppress || rd_suppress; // [RL7] [RL13]
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sub_level <= 1'b0;
        end else if (TIMING.line_start) begin
            // Shadow polarity: a software write shows only after the reload
            sub_level <= active.polarity; // [RL4]
        end else if (pulse_line && !blocked) begin
            if (first_hit ^ second_hit) begin
                sub_level <= ~sub_level; // [RL2] [RL5]
            end
        end else begin
            sub_level <= active.polarity;
        end
    end

    assign SUBSTRATE_PULSE = sub_level;

    // Field sequencer; a zero exposure count leaves the field untouched
    // Idle waits for a request, expose counts dark fields, readout counts
    // suppressed fields; every step happens only on a field edge, so a
    // request written mid-field always waits for the next edge
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= SEQ_IDLE;
            fields_left <= '0;
            joint_readout <= 1'b0;
            exp_suppress <= 1'b0;
            rd_suppress <= 1'b0;
            consume <= '0;
            SHUTTER_TRIGGER <= '0;
        end else begin
            consume <= '0;
            SHUTTER_TRIGGER <= '0;
            if (TIMING.field_start) begin
                // Shutter and bias requests leave as a one-cycle pulse
                SHUTTER_TRIGGER <= operation_trigger[TRIG_BIAS_HI:TRIG_SHUT_LO];
                consume[TRIG_BIAS_HI:TRIG_SHUT_LO] <= operation_trigger[TRIG_BIAS_HI:0];
                case (state)
                    SEQ_IDLE: begin
                        // Leftover suppression is cleared on every idle edge
                        exp_suppress <= 1'b0;
                        rd_suppress <= 1'b0;
                        if (operation_trigger[TRIG_EXPOSURE]) begin
                            state <= SEQ_EXPOSE; // [RL9]
                            fields_left <= exposure_field_count;
                            joint_readout <= operation_trigger[TRIG_READOUT];
                            consume[TRIG_EXPOSURE] <= 1'b1;
                            consume[TRIG_READOUT] <= operation_trigger[TRIG_READOUT];
                        end else if (operation_trigger[TRIG_READOUT]) begin
                            consume[TRIG_READOUT] <= 1'b1; // [RL15]
                            fields_left <= CNT_W'(readout_field_count);
                            // Readout alone starts suppressing at this edge
                            rd_suppress <= readout_wanted(readout_field_count); // [RL17]
                            state <= readout_wanted(readout_field_count) ? SEQ_READOUT : SEQ_IDLE;
                        end
                    end
                    SEQ_EXPOSE: begin
                        if (fields_left != '0) begin
                            // Dark field: gate follows exp_suppress, syncs too when sync-off is set
                            exp_suppress <= 1'b1; // [RL7] [RL22]
                            fields_left <= fields_left - 1'b1;
                        end else begin
                            exp_suppress <= 1'b0; // [RL10]
                            joint_readout <= 1'b0;
                            fields_left <= CNT_W'(readout_field_count);
                            // Joint trigger: readout follows with no idle field
                            rd_suppress <= joint_readout && readout_wanted(readout_field_count);
                            state <= joint_readout && readout_wanted(readout_field_count)
                                ? SEQ_READOUT : SEQ_IDLE; // [RL16]
                        end
                    end
                    SEQ_READOUT: begin
                        // The field that reaches one is the last suppressed
                        if (fields_left > 12'h001) begin
                            fields_left <= fields_left - 1'b1; // [RL13]
                        end else begin
                            fields_left <= '0;
                            rd_suppress <= 1'b0;
                            state <= SEQ_IDLE; // [RL12]
                        end
                    end
                    default: state <= SEQ_IDLE;
                endcase
            end
        end
    end

    // Enables come straight from the suppress flop; syncs stay on unless
    // software asked for them to be dropped while the sensor is dark
    assign SENSOR_GATE_ENABLE = !exp_suppress; // [RL7]
    assign SYNC_ENABLE = !(sync_off_during_exposure && exp_suppress); // [RL8]
    assign EXPOSING = state == SEQ_EXPOSE;
    assign READING = state == SEQ_READOUT;

endmodule

`default_nettype wire

// *** dv/shutter_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
module shutter_sva
    import shutter_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic REG_WE,
    input wire logic REG_RE,
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic [DATA_W-1:0] REG_WDATA,
    input wire logic [DATA_W-1:0] REG_RDATA,
    input wire timing_s TIMING,
    input wire logic SHUTTER_SIGNAL_THREE,
    input wire logic SUBSTRATE_PULSE,
    input wire logic SENSOR_GATE_ENABLE,
    input wire logic SYNC_ENABLE,
    input wire logic [TRIG_BIAS_HI:0] SHUTTER_TRIGGER,
    input wire logic EXPOSING,
    input wire logic READING
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_one_shot;
        $past(TIMING.field_start) ##1 (SHUTTER_TRIGGER == '0);
    endsequence
    chk_state_exclusive: assert property (!(EXPOSING && READING))
        else $error("exposure and readout active together");
    chk_expose_at_field: assert property ($rose(EXPOSING) |-> $past(TIMING.field_start))
        else $error("exposure began away from a field edge");
    chk_readout_at_field: assert property ($rose(READING) |-> $past(TIMING.field_start))
        else $error("readout began away from a field edge");
    chk_trigger_one_shot: assert property ((SHUTTER_TRIGGER != '0) |-> s_one_shot)
        else $error("shutter trigger pulse misplaced or too long");
    chk_sync_off_expose: assert property (!SYNC_ENABLE |-> EXPOSING || $past(EXPOSING))
        else $error("syncs stopped outside exposure");
    chk_gate_off_expose: assert property (!SENSOR_GATE_ENABLE |-> EXPOSING || $past(EXPOSING))
        else $error("gate blocked outside exposure");
    chk_unmapped_read: assert property (REG_RE && REG_ADDR == 8'h00 |=> REG_RDATA == '0)
        else $error("unmapped read returned data");
    chk_rdata_hold: assert property (!$past(REG_RE) |-> $stable(REG_RDATA))
        else $error("read data changed without a read");
endmodule
bind substrate_shutter_sequencer shutter_sva u_chk (.CLK(CLK), .RST_N(RST_N), .REG_WE(REG_WE),
    .REG_RE(REG_RE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .TIMING(TIMING), .SHUTTER_SIGNAL_THREE(SHUTTER_SIGNAL_THREE),
    .SUBSTRATE_PULSE(SUBSTRATE_PULSE), .SENSOR_GATE_ENABLE(SENSOR_GATE_ENABLE),
    .SYNC_ENABLE(SYNC_ENABLE), .SHUTTER_TRIGGER(SHUTTER_TRIGGER), .EXPOSING(EXPOSING),
    .READING(READING));
`default_nettype wire

// *** dv/timing_source.sv ***
`timescale 1ns/10ps
`default_nettype none
module timing_source
    import shutter_pkg::*;
#(
    parameter int LINE_LEN = 16,
    parameter int FIELD_LINES = 10
)
(
    input wire logic clk,
    input wire logic rst_n,
    output var timing_s timing
);
    int pix;
    int line;
    // Free running: sensor line timing never pauses
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pix <= 0;
            line <= 0;
        end else if (pix == LINE_LEN - 1) begin
            pix <= 0;
            line <= (line == FIELD_LINES - 1) ? 0 : line + 1;
        end else begin
            pix <= pix + 1;
        end
    end
    always_comb begin
        timing.line_start = (pix == 0);
        timing.field_start = (pix == 0) && (line == 0);
        timing.gate_line = (line == 1);
    end
endmodule
`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
    import shutter_pkg::*;
    logic clk;
    logic rst_n = 1'b0;
    logic we = 1'b0;
    logic re = 1'b0;
    logic sh3 = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic [DATA_W-1:0] rdata;
    timing_s timing;
    logic sub, gate_en, sync_en, expo, rding;
    logic [TRIG_BIAS_HI:0] shtrig;
    int n_errors = 0;
    int n_checks = 0;
    timing_source u_timing_source (.clk(clk), .rst_n(rst_n), .timing(timing));
    substrate_shutter_sequencer u_substrate_shutter_sequencer (.CLK(clk), .RST_N(rst_n),
        .REG_WE(we), .REG_RE(re), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
        .TIMING(timing), .SHUTTER_SIGNAL_THREE(sh3), .SUBSTRATE_PULSE(sub),
        .SENSOR_GATE_ENABLE(gate_en), .SYNC_ENABLE(sync_en), .SHUTTER_TRIGGER(shtrig),
        .EXPOSING(expo), .READING(rding));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic finish_test();
        if (n_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(string what, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic guard(inout int i);
        @(posedge clk);
        #1;
        i++;
        if (i > 3000) begin
            n_errors++;
            $display("unexpected wait: expected done seen timeout");
            finish_test();
        end
    endtask
    task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        we <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] exp);
        re <= 1'b1;
        addr <= a;
        @(posedge clk);
        re <= 1'b0;
        @(posedge clk);
        #1;
        chk("read data", exp, rdata);
    endtask
    // Rising edges of the substrate line over one whole field
    task automatic pulses(output int n);
        int i = 0;
        logic prev;
        n = 0;
        while (timing.field_start !== 1'b1) guard(i);
        guard(i);
        prev = sub;
        while (timing.field_start !== 1'b1) begin
            if (sub === 1'b1 && prev === 1'b0) n++;
            prev = sub;
            guard(i);
        end
    endtask
    task automatic watch(input bit rdg, output int f, output int r, output int s);
        int i = 0;
        logic prev;
        f = 0;
        r = 0;
        s = 0;
        while ((rdg ? rding : expo) !== 1'b1) guard(i);
        i = 0;
        prev = sub;
        while ((rdg ? rding : expo) === 1'b1) begin
            if (timing.field_start === 1'b1) f++;
            if (sub === 1'b1 && prev === 1'b0) r++;
            s |= {gate_en === 1'b0, sync_en === 1'b0};
            prev = sub;
            guard(i);
        end
    endtask
    task automatic s_normal();
        int n;
        wr(OFS_FIRST_PULSE_TOGGLES, 24'h005002);
        wr(OFS_POST_GATE_SUPPRESS, 24'h000001);
        wr(OFS_PULSES_PER_FIELD, 24'h000003);
        rd(OFS_PULSES_PER_FIELD, 24'h000003);
        pulses(n);
        pulses(n);
        chk("pulses per field", 24'd3, 24'(n));
    endtask
    task automatic s_precision();
        int n;
        wr(OFS_SECOND_PULSE_TOGGLES, 24'h009007);
        pulses(n);
        pulses(n);
        chk("pulses with extra", 24'd4, 24'(n));
        wr(OFS_SECOND_PULSE_TOGGLES, 24'hFFFFFF);
        pulses(n);
        pulses(n);
        chk("pulses extra off", 24'd3, 24'(n));
    endtask
    task automatic s_mask();
        int n;
        sh3 <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            wr(OFS_EXTRA_MASK_MODE, 24'(m));
            pulses(n);
            pulses(n);
            chk("masked pulses", (m == 2) ? 24'd0 : 24'd3, 24'(n));
        end
        sh3 <= 1'b0;
        wr(OFS_EXTRA_MASK_MODE, 24'h000000);
    endtask
    task automatic s_manual();
        int n;
        wr(OFS_POST_GATE_SUPPRESS, 24'h000FF0);
        pulses(n);
        pulses(n);
        chk("manual suppress", 24'h000000, 24'(n));
        wr(OFS_POST_GATE_SUPPRESS, 24'h000001);
        pulses(n);
        pulses(n);
        chk("manual release", 24'h000003, 24'(n));
    endtask
    task automatic s_trigger();
        int i = 0;
        wr(OFS_OPERATION_TRIGGER, 24'h00003F);
        while (shtrig === '0) guard(i);
        chk("shutter triggers", 24'h00003F, 24'(shtrig));
        guard(i);
        chk("shutter triggers", 24'h000000, 24'(shtrig));
    endtask
    task automatic s_expose();
        int f, r, s, n;
        wr(OFS_SYNC_OFF, 24'h000001);
        wr(OFS_EXPOSURE_FIELD_COUNT, 24'h000002);
        wr(OFS_OPERATION_TRIGGER, 24'h000040);
        watch(1'b0, f, r, s);
        chk("exposure fields", 24'd3, 24'(f));
        chk("exposure pulses", 24'd3, 24'(r));
        chk("sync and gate off", 24'd3, 24'(s));
        wr(OFS_EXPOSURE_FIELD_COUNT, 24'h000000);
        wr(OFS_OPERATION_TRIGGER, 24'h000040);
        pulses(n);
        pulses(n);
        chk("pulses per field", 24'd3, 24'(n));
    endtask
    task automatic s_readout();
        int f, r, s, n;
        wr(OFS_OPERATION_TRIGGER, 24'h000080);
        watch(1'b1, f, r, s);
        chk("readout fields", 24'd2, 24'(f));
        chk("readout pulses", 24'd0, 24'(r));
        rd(OFS_STATUS, 24'h000000);
        pulses(n);
        chk("pulses after readout", 24'h000003, 24'(n));
        wr(OFS_EXPOSURE_FIELD_COUNT, 24'h000001);
        wr(OFS_OPERATION_TRIGGER, 24'h0000C0);
        watch(1'b0, f, r, s);
        watch(1'b1, f, r, s);
        chk("readout fields", 24'd2, 24'(f));
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(OFS_PULSES_PER_FIELD, 24'h000001);
        rd(OFS_SECOND_PULSE_TOGGLES, 24'hFFFFFF);
        rd(8'h00, 24'h000000);
        wr(OFS_READOUT_FIELD_COUNT, 24'h000002);
        s_normal();
        s_precision();
        s_mask();
        s_manual();
        s_trigger();
        s_expose();
        s_readout();
        finish_test();
    end
endmodule
`default_nettype wire
